// File: shared/vop_pkg.sv
// Constants and types shared by the vertical overflow and row preset block
package vop_pkg;
   // I/O port addresses of the indexed CRT register file
   localparam logic [15:0] CRT_IDX_MONO = 16'h03b4;
   localparam logic [15:0] CRT_DATA_MONO = 16'h03b5;
   localparam logic [15:0] CRT_IDX_COLOR = 16'h03d4;
   localparam logic [15:0] CRT_DATA_COLOR = 16'h03d5;
   // Register indices behind the data port
   localparam logic [7:0] IDX_VTOTAL_LOW = 8'h06;
   localparam logic [7:0] IDX_OVERFLOW = 8'h07;
   localparam logic [7:0] IDX_PRESET_ROW = 8'h08;
   localparam logic [7:0] IDX_MAX_SCAN = 8'h09;
   localparam logic [7:0] IDX_VSYNC_LOW = 8'h10;
   localparam logic [7:0] IDX_VSYNC_END = 8'h11;
   localparam logic [7:0] IDX_VDISP_LOW = 8'h12;
   localparam logic [7:0] IDX_VBLANK_LOW = 8'h15;
   localparam logic [7:0] IDX_EXT_TOTAL = 8'h30;
   localparam logic [7:0] IDX_EXT_DISP = 8'h31;
   localparam logic [7:0] IDX_EXT_SYNC = 8'h32;
   localparam logic [7:0] IDX_EXT_BLANK = 8'h33;
   localparam logic [7:0] IDX_IO_CONTROL = 8'h80;
   // Field order of the four vertical values
   localparam int FLD_TOTAL = 0;
   localparam int FLD_DISP = 1;
   localparam int FLD_SYNC = 2;
   localparam int FLD_BLANK = 3;
   localparam int NUM_FLD = 4;
   // Overflow bit positions, then max scan, I/O control and protect bits
   localparam int OVF_VT_B8 = 0;
   localparam int OVF_VDE_B8 = 1;
   localparam int OVF_VSS_B8 = 2;
   localparam int OVF_VBS_B8 = 3;
   localparam int OVF_VT_B9 = 5;
   localparam int OVF_VDE_B9 = 6;
   localparam int OVF_VSS_B9 = 7;
   localparam int MSL_VBS_B9 = 5;
   localparam int IOM_EXT_BIT = 0;
   localparam int PROT_BIT = 7;
   // Overflow bits locked by group-zero protection (bit 4 stays open)
   localparam logic [7:0] OVF_PROT_MASK = 8'hef;
   // Preset row scan: bit 7 reserved, pan at 6:5, row at 4:0
   localparam logic [7:0] PRS_WR_MASK = 8'h7f;
   localparam int PRS_PAN_LSB = 5;
   localparam int PRS_PAN_MSB = 6;
   localparam int PRS_ROW_MSB = 4;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [11:0] RST_LINE = 12'h000;
   // Frame holds programmed total plus this many lines
   localparam logic [12:0] VT_EXTRA = 13'h0002;
   // Assembled vertical timing set
   typedef struct packed {
      logic [11:0] total;
      logic [11:0] dispEnd;
      logic [11:0] syncStart;
      logic [11:0] blankStart;
   } vop_vtiming_t;
endpackage

// File: core/vop_vfield.sv
// Assembles one 10- or 12-bit vertical timing value
`timescale 1ns/1ns
module vop_vfield (
   input wire logic extMode,
   input wire logic [7:0] lowByte,
   input wire logic [3:0] extNib,
   input wire logic bit9,
   input wire logic bit8,
   output logic [11:0] value
);
   // Extended mode ignores both overflow bits entirely
   always_comb begin
      if (extMode) begin
         value = {extNib, lowByte};
      end else begin
         value = {2'b00, bit9, bit8, lowByte};
      end
   end
endmodule

// File: core/vop_vertical.sv
// Vertical timing assembly, preset row scan and vertical counter
//
// Operation
// - Mode bit selects standard or 12-bit timing
// - Standard blank start uses scan bit5, overflow bit3
// - Extended blank start upper nibble from extension
// - Standard sync start uses overflow bits 7, 2
// - Extended sync start upper nibble from extension
// - Standard display end uses overflow bits 6, 1
// - Extended display end upper nibble from extension
// - Standard total uses overflow bits 5, 0
// - Extended total upper nibble from extension
// - Frame spans programmed total plus two lines
// - Active lines run zero through display end
// - Blanking begins on line equal blank start
// - Sync begins on line equal sync start
// - Preset row reached at index 08h, top zero
// - Reserved top preset bit reads as zero
// - Two-bit field pans zero to three bytes
// - Nine-pixel text pans by nine pixel steps
// - Eight-pixel and graphics pan by eight pixels
// - Fine pixel pan adds to byte pan
// - Row field picks first shown box line
// - Protection locks overflow bits except bit four
`timescale 1ns/1ns
module vop_vertical (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [15:0] ioAddr,
   input wire logic ioWrStb,
   input wire logic ioRdStb,
   input wire logic [7:0] ioWrData,
   output logic [7:0] ioRdData,
   output logic ioRdValid,
   input wire logic lineTick,
   input wire logic textMode,
   input wire logic nineDotChar,
   input wire logic [3:0] attrPixelPan,
   output vop_pkg::vop_vtiming_t vTiming,
   output logic extMode,
   output logic [11:0] lineCount,
   output logic vDispEn,
   output logic vBlank,
   output logic vSync,
   output logic [1:0] bytePan,
   output logic [5:0] panShift,
   output logic [4:0] startRowScan
);
   import vop_pkg::*;

   logic [7:0] idxQ, idxD, vtlQ, vtlD, ovfQ, ovfD, prsQ, prsD;
   logic [7:0] mslQ, mslD, vslQ, vslD, vepQ, vepD, vdlQ, vdlD;
   logic [7:0] vblQ, vblD, iomQ, iomD;
   logic [3:0] extQ [NUM_FLD];
   logic [3:0] extD [NUM_FLD];
   logic [7:0] rdDataQ, rdDataD;
   logic rdValidQ, rdValidD;
   logic dataSel, idxSel, dataWr, idxWr, dataRd;
   logic [7:0] lowSel [NUM_FLD];
   logic b9Sel [NUM_FLD];
   logic b8Sel [NUM_FLD];
   logic [11:0] asmVal [NUM_FLD];
   vop_vtiming_t asmTm, tmQ, tmD;
   logic [7:0] prsShQ, prsShD;
   logic extModeQ, extModeD;
   logic [11:0] lineQ, lineD;
   logic frameEnd;
   logic dispQ, dispD, blankQ, blankD, syncQ, syncD;
   logic [5:0] panQ, panD;
   logic [5:0] coarse;

   // Data port answers at either the mono or the colour address
   // data port decode
   always_comb begin
      dataSel = (ioAddr == CRT_DATA_MONO) || (ioAddr == CRT_DATA_COLOR);
      idxSel = (ioAddr == CRT_IDX_MONO) || (ioAddr == CRT_IDX_COLOR);
      dataWr = ioWrStb && dataSel;
      idxWr = ioWrStb && idxSel;
      dataRd = ioRdStb && dataSel;
   end

   // Register file next values
   always_comb begin
      idxD = idxQ;
      vtlD = vtlQ;
      ovfD = ovfQ;
      prsD = prsQ;
      mslD = mslQ;
      vslD = vslQ;
      vepD = vepQ;
      vdlD = vdlQ;
      vblD = vblQ;
      iomD = iomQ;
      for (int i = 0; i < NUM_FLD; i++) begin
         extD[i] = extQ[i];
      end
      if (idxWr) begin
         idxD = ioWrData;
      end
      if (dataWr) begin
         case (idxQ)
            IDX_VTOTAL_LOW: begin
               if (!vepQ[PROT_BIT]) begin
                  vtlD = ioWrData;
               end
            end
            IDX_OVERFLOW: begin
               if (vepQ[PROT_BIT]) begin
                  ovfD = (ovfQ & OVF_PROT_MASK) | (ioWrData & ~OVF_PROT_MASK);
               end else begin
                  ovfD = ioWrData;
               end
            end
            IDX_PRESET_ROW: prsD = ioWrData & PRS_WR_MASK;
            IDX_MAX_SCAN: mslD = ioWrData;
            IDX_VSYNC_LOW: vslD = ioWrData;
            IDX_VSYNC_END: vepD = ioWrData;
            IDX_VDISP_LOW: vdlD = ioWrData;
            IDX_VBLANK_LOW: vblD = ioWrData;
            IDX_EXT_TOTAL: extD[FLD_TOTAL] = ioWrData[3:0];
            IDX_EXT_DISP: extD[FLD_DISP] = ioWrData[3:0];
            IDX_EXT_SYNC: extD[FLD_SYNC] = ioWrData[3:0];
            IDX_EXT_BLANK: extD[FLD_BLANK] = ioWrData[3:0];
            IDX_IO_CONTROL: iomD = ioWrData;
            default: idxD = idxD;
         endcase
      end
   end

   // Read data; unmapped indices read as zero
   always_comb begin
      rdDataD = rdDataQ;
      rdValidD = 1'b0;
      if (ioRdStb && idxSel) begin
         rdDataD = idxQ;
         rdValidD = 1'b1;
      end else if (dataRd) begin
         rdValidD = 1'b1;
         case (idxQ)
            IDX_VTOTAL_LOW: rdDataD = vtlQ;
            IDX_OVERFLOW: rdDataD = ovfQ;
            IDX_PRESET_ROW: rdDataD = prsQ & PRS_WR_MASK;
            IDX_MAX_SCAN: rdDataD = mslQ;
            IDX_VSYNC_LOW: rdDataD = vslQ;
            IDX_VSYNC_END: rdDataD = vepQ;
            IDX_VDISP_LOW: rdDataD = vdlQ;
            IDX_VBLANK_LOW: rdDataD = vblQ;
            IDX_EXT_TOTAL: rdDataD = {4'h0, extQ[FLD_TOTAL]};
            IDX_EXT_DISP: rdDataD = {4'h0, extQ[FLD_DISP]};
            IDX_EXT_SYNC: rdDataD = {4'h0, extQ[FLD_SYNC]};
            IDX_EXT_BLANK: rdDataD = {4'h0, extQ[FLD_BLANK]};
            IDX_IO_CONTROL: rdDataD = iomQ;
            default: rdDataD = RST_BYTE;
         endcase
      end
   end

   // Source bits for each value; blank bit 9 lives in max scan line
   // standard overflow bit sources
   always_comb begin
      lowSel[FLD_TOTAL] = vtlQ;
      b9Sel[FLD_TOTAL] = ovfQ[OVF_VT_B9];
      b8Sel[FLD_TOTAL] = ovfQ[OVF_VT_B8];
      lowSel[FLD_DISP] = vdlQ;
      b9Sel[FLD_DISP] = ovfQ[OVF_VDE_B9];
      b8Sel[FLD_DISP] = ovfQ[OVF_VDE_B8];
      lowSel[FLD_SYNC] = vslQ;
      b9Sel[FLD_SYNC] = ovfQ[OVF_VSS_B9];
      b8Sel[FLD_SYNC] = ovfQ[OVF_VSS_B8];
      lowSel[FLD_BLANK] = vblQ;
      b9Sel[FLD_BLANK] = mslQ[MSL_VBS_B9];
      b8Sel[FLD_BLANK] = ovfQ[OVF_VBS_B8];
   end

   // one assembler per value, mode bit steers width
   for (genvar g = 0; g < NUM_FLD; g++) begin : gFld
      vop_vfield uField (
         .extMode(iomQ[IOM_EXT_BIT]),
         .lowByte(lowSel[g]),
         .extNib(extQ[g]),
         .bit9(b9Sel[g]),
         .bit8(b8Sel[g]),
         .value(asmVal[g])
      );
   end

   always_comb begin
      asmTm.total = asmVal[FLD_TOTAL];
      asmTm.dispEnd = asmVal[FLD_DISP];
      asmTm.syncStart = asmVal[FLD_SYNC];
      asmTm.blankStart = asmVal[FLD_BLANK];
   end

   // frame ends after total plus two lines; >= guards a shrink
   assign frameEnd = lineTick &&
      ({1'b0, lineQ} + 13'h0001 >= {1'b0, tmQ.total} + VT_EXTRA);

   // Vertical counter and shadow copies; shadows swap only at wrap so a
   // half-written mode never tears the frame on screen
   always_comb begin
      tmD = tmQ;
      prsShD = prsShQ;
      extModeD = extModeQ;
      lineD = lineQ;
      dispD = dispQ;
      blankD = blankQ;
      syncD = syncQ;
      if (lineTick) begin
         lineD = lineQ + 12'h001;
      end
      // apply new values at frame start
      if (frameEnd) begin
         lineD = RST_LINE;
         tmD = asmTm;
         prsShD = prsQ;
         extModeD = iomQ[IOM_EXT_BIT];
      end
      if (lineTick) begin
         dispD = (lineD <= tmD.dispEnd);
         // blank set wins over frame clear
         if (lineD == tmD.blankStart) begin
            blankD = 1'b1;
         end else if (lineD == RST_LINE) begin
            blankD = 1'b0;
         end
         // sync start; ends on sync end nibble match
         if (lineD == tmD.syncStart) begin
            syncD = 1'b1;
         end else if (lineD[3:0] == vepQ[3:0]) begin
            syncD = 1'b0;
         end
      end
   end

   // Coarse pan times 9 or 8 pixels, plus fine pixel pan
   always_comb begin
      coarse = {4'h0, prsShQ[PRS_PAN_MSB:PRS_PAN_LSB]};
      if (textMode && nineDotChar) begin
         panD = (coarse << 3) + coarse + {2'b00, attrPixelPan};
      end else begin
         panD = (coarse << 3) + {2'b00, attrPixelPan};
      end
   end

   // State registers
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         idxQ <= RST_BYTE;
         vtlQ <= RST_BYTE;
         ovfQ <= RST_BYTE;
         prsQ <= RST_BYTE;
         mslQ <= RST_BYTE;
         vslQ <= RST_BYTE;
         vepQ <= RST_BYTE;
         vdlQ <= RST_BYTE;
         vblQ <= RST_BYTE;
         iomQ <= RST_BYTE;
         for (int i = 0; i < NUM_FLD; i++) begin
            extQ[i] <= 4'h0;
         end
         rdDataQ <= RST_BYTE;
         rdValidQ <= 1'b0;
         tmQ <= '0;
         prsShQ <= RST_BYTE;
         extModeQ <= 1'b0;
         lineQ <= RST_LINE;
         dispQ <= 1'b0;
         blankQ <= 1'b0;
         syncQ <= 1'b0;
         panQ <= 6'h00;
      end else begin
         idxQ <= idxD;
         vtlQ <= vtlD;
         ovfQ <= ovfD;
         prsQ <= prsD;
         mslQ <= mslD;
         vslQ <= vslD;
         vepQ <= vepD;
         vdlQ <= vdlD;
         vblQ <= vblD;
         iomQ <= iomD;
         for (int i = 0; i < NUM_FLD; i++) begin
            extQ[i] <= extD[i];
         end
         rdDataQ <= rdDataD;
         rdValidQ <= rdValidD;
         tmQ <= tmD;
         prsShQ <= prsShD;
         extModeQ <= extModeD;
         lineQ <= lineD;
         dispQ <= dispD;
         blankQ <= blankD;
         syncQ <= syncD;
         panQ <= panD;
      end
   end

   // Outputs straight from flops
   assign ioRdData = rdDataQ;
   assign ioRdValid = rdValidQ;
   assign vTiming = tmQ;
   assign extMode = extModeQ;
   assign lineCount = lineQ;
   assign vDispEn = dispQ;
   assign vBlank = blankQ;
   assign vSync = syncQ;
   // shadowed pan and first row line
   assign bytePan = prsShQ[PRS_PAN_MSB:PRS_PAN_LSB];
   assign startRowScan = prsShQ[PRS_ROW_MSB:0];
   assign panShift = panQ;

   a_std_total: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !iomQ[IOM_EXT_BIT] |-> asmTm.total ==
      {2'b00, ovfQ[OVF_VT_B9], ovfQ[OVF_VT_B8], vtlQ})
      else $error("standard total misassembled");
   a_ext_sync: assert property (@(posedge sys_clk) disable iff (sys_rst)
      iomQ[IOM_EXT_BIT] |-> asmTm.syncStart ==
      {extQ[FLD_SYNC], vslQ})
      else $error("extended sync start misassembled");
   a_std_blank: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !iomQ[IOM_EXT_BIT] |-> asmTm.blankStart[9:8] ==
      {mslQ[MSL_VBS_B9], ovfQ[OVF_VBS_B8]})
      else $error("standard blank start misassembled");
   a_frame_wrap: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (lineTick && lineQ == tmQ.total + 12'h001) |=> lineQ == RST_LINE)
      else $error("frame did not wrap at total plus two");
   a_disp_end: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (lineTick && !frameEnd && lineQ == tmQ.dispEnd) |=> !vDispEn)
      else $error("display enable past last active line");
   a_blank_begin: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (lineTick && !frameEnd && lineQ + 12'h001 == tmQ.blankStart)
      |=> vBlank)
      else $error("blanking missed its start line");
   a_sync_begin: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (lineTick && !frameEnd && lineQ + 12'h001 == tmQ.syncStart)
      |=> vSync)
      else $error("sync missed its start line");
   a_prot_lock: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (dataWr && idxQ == IDX_OVERFLOW && vepQ[PROT_BIT])
      |=> (ovfQ & OVF_PROT_MASK) == ($past(ovfQ) & OVF_PROT_MASK))
      else $error("protected overflow bits changed");
   a_rsvd_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (dataRd && idxQ == IDX_PRESET_ROW) |=> !ioRdData[7])
      else $error("reserved preset bit read as one");
   a_frame_apply: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !$stable(prsShQ) |-> $past(frameEnd))
      else $error("preset row applied mid frame");
   a_pan_nine: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (textMode && nineDotChar) |=> panShift == 6'd9 *
      $past(prsShQ[6:5]) + $past(attrPixelPan))
      else $error("nine-pixel pan wrong");
endmodule

// File: dv/vop_monitor.sv
// Display monitor model: makes line strobes and measures each frame
`timescale 1ns/1ns
module vop_monitor #(
   parameter int TICK = 4
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   output logic lineTick,
   input wire logic [11:0] lineCount,
   input wire logic vDispEn,
   input wire logic vBlank,
   input wire logic vSync,
   output int frameLines,
   output int dispLines,
   output logic [11:0] blankLine,
   output logic [11:0] syncLine
);
   int div, cnt, dcnt;
   logic tickD, blankP, syncP;
   // Strobe every TICK clocks; levels are read one clock after it
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         div <= 0;
         lineTick <= 1'b0;
         tickD <= 1'b0;
      end else begin
         div <= (div == TICK - 1) ? 0 : div + 1;
         lineTick <= (div == TICK - 1);
         tickD <= lineTick;
      end
   end
   // Frame length, active lines, first blank and sync lines
   always @(posedge sys_clk) begin
      if (tickD) begin
         blankP <= vBlank;
         syncP <= vSync;
         if (vBlank && !blankP) blankLine <= lineCount;
         if (vSync && !syncP) syncLine <= lineCount;
         cnt <= (lineCount == 12'h000) ? 1 : cnt + 1;
         if (lineCount == 12'h000) begin
            frameLines <= cnt;
            dispLines <= dcnt;
            dcnt <= int'(vDispEn);
         end else begin
            dcnt <= dcnt + int'(vDispEn);
         end
      end
   end
endmodule

// File: dv/vop_vertical_tb.sv
// Self-checking bench for vertical timing and preset row scan
`timescale 1ns/1ns
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin \
   mismatches++; $display("BAD %0t %s", $time, m); end end
module vop_vertical_tb;
   import vop_pkg::*;
   localparam int TICK = 4;
   logic sys_clk, sys_rst, ioWrStb, ioRdStb, ioRdValid, lineTick;
   logic textMode, nineDotChar, extMode, vDispEn, vBlank, vSync;
   logic [15:0] ioAddr;
   logic [7:0] ioWrData, ioRdData, ovf, msl;
   logic [3:0] attrPixelPan;
   vop_vtiming_t vTiming;
   logic [11:0] lineCount, blankLine, syncLine;
   logic [1:0] bytePan;
   logic [5:0] panShift;
   logic [4:0] startRowScan;
   int frameLines, dispLines, mismatches, num_checks;
   logic [31:0] rnd;
   logic [7:0] expQ[$];
   logic [7:0] lo[4];
   logic [3:0] nb[4];
   logic [7:0] lowIdx[4], extIdx[4];
   vop_vertical vop_vertical_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .ioAddr(ioAddr), .ioWrStb(ioWrStb), .ioRdStb(ioRdStb),
      .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdValid(ioRdValid),
      .lineTick(lineTick), .textMode(textMode), .nineDotChar(nineDotChar),
      .attrPixelPan(attrPixelPan), .vTiming(vTiming), .extMode(extMode),
      .lineCount(lineCount), .vDispEn(vDispEn), .vBlank(vBlank),
      .vSync(vSync), .bytePan(bytePan), .panShift(panShift),
      .startRowScan(startRowScan));
   vop_monitor #(.TICK(TICK)) vop_monitor_inst (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .lineTick(lineTick), .lineCount(lineCount),
      .vDispEn(vDispEn), .vBlank(vBlank), .vSync(vSync),
      .frameLines(frameLines), .dispLines(dispLines),
      .blankLine(blankLine), .syncLine(syncLine));
   // Shift register source of random values
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Index then data, strobe held for both back-to-back writes
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, bit mono);
      @(negedge sys_clk);
      ioAddr = mono ? CRT_IDX_MONO : CRT_IDX_COLOR;
      ioWrData = idx;
      ioWrStb = 1'b1;
      @(negedge sys_clk);
      ioAddr = mono ? CRT_DATA_MONO : CRT_DATA_COLOR;
      ioWrData = d;
      @(negedge sys_clk);
      ioWrStb = 1'b0;
   endtask
   // Read notes its expected byte for the watcher
   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      @(negedge sys_clk);
      ioAddr = CRT_IDX_COLOR;
      ioWrData = idx;
      ioWrStb = 1'b1;
      @(negedge sys_clk);
      ioWrStb = 1'b0;
      ioAddr = CRT_DATA_COLOR;
      ioRdStb = 1'b1;
      expQ.push_back(e);
      @(negedge sys_clk);
      ioRdStb = 1'b0;
   endtask
   // Bounded wait for the next wrap to line zero
   task automatic wait_frame();
      int n;
      n = 0;
      while (lineCount === 12'h000 && n < 20000) begin
         @(negedge sys_clk);
         n++;
      end
      while (lineCount !== 12'h000 && n < 20000) begin
         @(negedge sys_clk);
         n++;
      end
      `CHK(n < 20000, 1'b1, "frame wait")
      repeat (TICK + 2) @(negedge sys_clk);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // Read data taken off the queue as each answer appears
   always @(negedge sys_clk) begin
      if (ioRdValid === 1'b1) begin
         `CHK(expQ.size() > 0, 1'b1, "unexpected read answer")
         if (expQ.size() > 0) `CHK(ioRdData, expQ.pop_front(), "rd")
      end
   end
   // Cut a hang short
   initial begin
      #(8 * 60000);
      mismatches++;
      $display("BAD %0t watchdog", $time);
      give_verdict();
   end
   initial begin
      {ioWrStb, ioRdStb, textMode, nineDotChar} = 4'h0;
      {ioAddr, ioWrData, attrPixelPan} = 28'h0;
      mismatches = 0;
      num_checks = 0;
      rnd = 32'hcc076007;
      lowIdx = '{IDX_VTOTAL_LOW, IDX_VDISP_LOW, IDX_VSYNC_LOW, IDX_VBLANK_LOW};
      extIdx = '{IDX_EXT_TOTAL, IDX_EXT_DISP, IDX_EXT_SYNC, IDX_EXT_BLANK};
      sys_rst = 1'b1;
      repeat (12) @(negedge sys_clk);
      sys_rst = 1'b0;
      rd(IDX_PRESET_ROW, 8'h00);
      wr(IDX_PRESET_ROW, 8'hff, 1'b1);
      rd(IDX_PRESET_ROW, 8'h7f);
      rd(8'h40, 8'h00);
      // Small standard frame measured by the monitor
      wr(lowIdx[0], 8'd38, 0);
      wr(lowIdx[1], 8'd29, 0);
      wr(lowIdx[2], 8'd33, 0);
      wr(lowIdx[3], 8'd31, 0);
      repeat (3) wait_frame();
      `CHK(frameLines, 40, "frame length")
      `CHK(dispLines, 30, "active lines")
      `CHK(blankLine, 12'd31, "blank line")
      `CHK(syncLine, 12'd33, "sync line")
      wr(lowIdx[0], 8'd100, 0);
      `CHK(vTiming.total, 12'd38, "early total")
      wait_frame();
      `CHK(vTiming.total, 12'd100, "late total")
      // Random values in both modes; unused high bits set too
      for (int m = 0; m < 4; m++) begin
         for (int f = 0; f < 4; f++) begin
            rnd = lfsr(rnd);
            lo[f] = rnd[7:0];
            nb[f] = (f == 0) ? {3'b000, rnd[8]} : rnd[11:8];
            wr(lowIdx[f], lo[f], rnd[12]);
            wr(extIdx[f], {4'h0, nb[f]}, 0);
         end
         rnd = lfsr(rnd);
         ovf = rnd[7:0];
         msl = rnd[15:8];
         wr(IDX_OVERFLOW, ovf, 0);
         wr(IDX_MAX_SCAN, msl, 0);
         wr(IDX_IO_CONTROL, {7'h00, m[1]}, 0);
         wait_frame();
         `CHK(extMode, m[1], "mode")
         if (m[1]) begin
            `CHK(vTiming.total, {nb[0], lo[0]}, "ext total")
            `CHK(vTiming.dispEnd, {nb[1], lo[1]}, "ext disp")
            `CHK(vTiming.syncStart, {nb[2], lo[2]}, "ext sync")
            `CHK(vTiming.blankStart, {nb[3], lo[3]}, "ext blank")
         end else begin
            `CHK(vTiming.total, {2'b0, ovf[5], ovf[0], lo[0]}, "vt")
            `CHK(vTiming.dispEnd, {2'b0, ovf[6], ovf[1], lo[1]}, "vd")
            `CHK(vTiming.syncStart, {2'b0, ovf[7], ovf[2], lo[2]}, "vs")
            `CHK(vTiming.blankStart, {2'b0, msl[5], ovf[3], lo[3]}, "vb")
         end
      end
      wr(IDX_OVERFLOW, 8'h00, 0);
      wr(IDX_VSYNC_END, 8'h80, 0);
      wr(IDX_OVERFLOW, 8'hff, 1);
      rd(IDX_OVERFLOW, 8'h10);
      wr(IDX_VSYNC_END, 8'h00, 0);
      wr(IDX_OVERFLOW, 8'h00, 0);
      wr(IDX_IO_CONTROL, 8'h00, 0);
      wr(lowIdx[0], 8'd10, 0);
      // Every pan code in graphics, nine-pixel text and eight-pixel text
      for (int k = 0; k < 12; k++) begin
         rnd = lfsr(rnd);
         textMode = (k >= 4);
         nineDotChar = (k < 8);
         attrPixelPan = rnd[3:0];
         wr(IDX_PRESET_ROW, {1'b0, k[1:0], rnd[8:4]}, 0);
         wait_frame();
         `CHK(bytePan, k[1:0], "byte pan")
         `CHK(startRowScan, rnd[8:4], "row scan")
         `CHK(panShift, 6'(k[1:0] * ((k >= 4 && k < 8) ? 9 : 8)) + 6'(rnd[3:0]),
            "pan shift")
      end
      // Software leaves the top text row unclipped
      wr(IDX_PRESET_ROW, 8'h00, 0);
      repeat (4) @(negedge sys_clk);
      `CHK(expQ.size(), 0, "reads unanswered")
      give_verdict();
   end
endmodule
